// >>> inc/gate_current_pkg.sv
// constants for the gate-driver current configuration register bank
// -----------------------------------------------------------------------------
// Overview of operation
// - select bit zero applies static set one
// - select bit one applies static set two
// - set two code bits 7:4, reset 0100
// - set one code bits 3:0, reset 0100
// - static select register only on page zero
// - precharge register only on page one
// - three 5-bit precharge codes, reset 00110
// - bit 15 reserved, always reads zero
// - active charge register, offset 0b, page zero
// - three 5-bit active charge codes, reset 00110
// - freewheel register, offset 0b, page one
// - one freewheel code charges and discharges
// - freewheel code used at switch-on and off
// -----------------------------------------------------------------------------
package gate_current_pkg;
   // ---------------------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------------------
   localparam logic [4:0]  OFS_STATIC_OR_PRECHARGE = 5'h0a; // page 0 / page 1
   localparam logic [4:0]  OFS_ACTIVE_OR_FREEWHEEL = 5'h0b; // page 0 / page 1
   localparam int          ADDR_W                  = 5;
   localparam int          DATA_W                  = 16;
   // ---------------------------------------------------------------------------
   // reset values and writable bits
   // ---------------------------------------------------------------------------
   localparam logic [15:0] RST_STATIC_SELECT       = 16'h0044;
   localparam logic [15:0] RST_PWM_CODES           = 16'h18c6;
   localparam logic [15:0] MASK_ALL                = 16'hffff;
   localparam logic [15:0] MASK_NO_RESERVED        = 16'h7fff; // bit 15 reserved
   // ---------------------------------------------------------------------------
   // field layout
   // ---------------------------------------------------------------------------
   localparam int          NUM_BRIDGES             = 8;
   localparam int          BRIDGE_SEL_LSB          = 8;  // bridge 1 at bit 8
   localparam int          STATIC_CODE_W           = 4;
   localparam int          STATIC_CODE_B_LSB       = 4;  // bits 7:4
   localparam int          STATIC_CODE_A_LSB       = 0;  // bits 3:0
   localparam int          NUM_PWM_CH              = 3;
   localparam int          PWM_CODE_W              = 5;  // ch1 4:0, ch2 9:5, ch3 14:10
   localparam int          PWM_FIELDS_W            = NUM_PWM_CH * PWM_CODE_W;
   localparam int          BRIDGE_CODES_W          = NUM_BRIDGES * STATIC_CODE_W;
endpackage : gate_current_pkg

// >>> hw/cfg_word_reg.sv
// one masked configuration word with synchronous reset
`timescale 1ns/100ps
`default_nettype none
module cfg_word_reg #(
   parameter logic [15:0] RESET_VALUE = 16'h0000,
   parameter logic [15:0] WRITE_MASK  = 16'hffff
) (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_write,
   input  wire logic [15:0] i_wdata,
   output var  logic [15:0] o_value
);
   logic [15:0] next_value; // value for the next edge

   // ---------------------------------------------------------------------------
   // next value: masked bits never take a one, so reserved bits stay zero
   // ---------------------------------------------------------------------------
   always_comb begin
      next_value = o_value;
      if (i_write) begin
         next_value = i_wdata & WRITE_MASK;
      end
   end

   // store the word
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_value <= RESET_VALUE;
      end else begin
         o_value <= next_value;
      end
   end
endmodule : cfg_word_reg
`default_nettype wire

// >>> hw/gate_drive_current_regs.sv
// gate-driver current configuration register bank with page select
`timescale 1ns/100ps
`default_nettype none
module gate_drive_current_regs (
   input  wire logic                                   i_clk,
   input  wire logic                                   i_reset_n,
   input  wire logic                                   i_page,
   input  wire logic                                   i_wr_en,
   input  wire logic                                   i_rd_en,
   input  wire logic [gate_current_pkg::ADDR_W-1:0]    i_addr,
   input  wire logic [gate_current_pkg::DATA_W-1:0]    i_wdata,
   output var  logic [gate_current_pkg::DATA_W-1:0]    o_rdata,
   output var  logic                                   o_rd_valid,
   output var  logic [gate_current_pkg::BRIDGE_CODES_W-1:0] o_bridge_current,
   output var  logic [gate_current_pkg::PWM_FIELDS_W-1:0]   o_precharge_start,
   output var  logic [gate_current_pkg::PWM_FIELDS_W-1:0]   o_active_charge,
   output var  logic [gate_current_pkg::PWM_FIELDS_W-1:0]   o_freewheel_on,
   output var  logic [gate_current_pkg::PWM_FIELDS_W-1:0]   o_freewheel_off
);
   import gate_current_pkg::*;

   // ---------------------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------------------
   logic        hit_a;              // shared offset 0a
   logic        hit_b;              // shared offset 0b
   logic        wr_static;          // write static select word
   logic        wr_precharge;       // write precharge start word
   logic        wr_active;          // write active charge word
   logic        wr_freewheel;       // write freewheel word
   logic [15:0] static_select;      // static select word
   logic [15:0] precharge_start;    // precharge start word
   logic [15:0] active_charge;      // active charge word
   logic [15:0] freewheel;          // freewheel word

   // page bit picks one of the two words that share each offset
   always_comb begin
      hit_a        = (i_addr == OFS_STATIC_OR_PRECHARGE);
      hit_b        = (i_addr == OFS_ACTIVE_OR_FREEWHEEL);
      wr_static    = i_wr_en && hit_a && !i_page;
      wr_precharge = i_wr_en && hit_a &&  i_page;
      wr_active    = i_wr_en && hit_b && !i_page;
      wr_freewheel = i_wr_en && hit_b &&  i_page;
   end

   // ---------------------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------------------
   // static word: every bit writable, codes reset to 0100 each
   cfg_word_reg #(.RESET_VALUE(RST_STATIC_SELECT), .WRITE_MASK(MASK_ALL)) u_static (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_write   (wr_static),
      .i_wdata   (i_wdata),
      .o_value   (static_select)
   );
   // pwm words: reserved top bit masked off so it always reads zero
   cfg_word_reg #(.RESET_VALUE(RST_PWM_CODES), .WRITE_MASK(MASK_NO_RESERVED)) u_precharge (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_write   (wr_precharge),
      .i_wdata   (i_wdata),
      .o_value   (precharge_start)
   );
   cfg_word_reg #(.RESET_VALUE(RST_PWM_CODES), .WRITE_MASK(MASK_NO_RESERVED)) u_active (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_write   (wr_active),
      .i_wdata   (i_wdata),
      .o_value   (active_charge)
   );
   cfg_word_reg #(.RESET_VALUE(RST_PWM_CODES), .WRITE_MASK(MASK_NO_RESERVED)) u_freewheel (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_write   (wr_freewheel),
      .i_wdata   (i_wdata),
      .o_value   (freewheel)
   );

   // ---------------------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------------------
   logic [15:0] next_rdata;    // data for the next read answer
   logic        next_rd_valid; // read answer strobe

   // a read shows the word held before any write in the same cycle
   always_comb begin
      next_rdata    = '0;
      next_rd_valid = i_rd_en;
      if (i_rd_en) begin
         if (hit_a) begin
            next_rdata = i_page ? precharge_start : static_select;
         end else if (hit_b) begin
            next_rdata = i_page ? freewheel : active_charge;
         end else begin
            next_rdata = '0; // other offsets belong to other blocks
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_rdata    <= '0;
         o_rd_valid <= 1'b0;
      end else begin
         o_rdata    <= next_rdata;
         o_rd_valid <= next_rd_valid;
      end
   end

   // ---------------------------------------------------------------------------
   // current codes to the analog drivers
   // ---------------------------------------------------------------------------
   logic [BRIDGE_CODES_W-1:0] next_bridge_current; // per-bridge static code
   logic [STATIC_CODE_W-1:0]  code_a;              // static set one
   logic [STATIC_CODE_W-1:0]  code_b;              // static set two
   logic [PWM_FIELDS_W-1:0]   next_precharge;      // precharge codes, reserved bit dropped
   logic [PWM_FIELDS_W-1:0]   next_active;         // active charge codes
   logic [PWM_FIELDS_W-1:0]   next_freewheel;      // freewheel codes, both transitions

   // each bridge takes set one or set two from its own select bit
   always_comb begin
      code_a = static_select[STATIC_CODE_A_LSB +: STATIC_CODE_W];
      code_b = static_select[STATIC_CODE_B_LSB +: STATIC_CODE_W];
      next_bridge_current = '0;
      for (int i = 0; i < NUM_BRIDGES; i++) begin
         if (static_select[BRIDGE_SEL_LSB + i]) begin
            next_bridge_current[i*STATIC_CODE_W +: STATIC_CODE_W] = code_b;
         end else begin
            next_bridge_current[i*STATIC_CODE_W +: STATIC_CODE_W] = code_a;
         end
      end
      // the pwm codes pass through unchanged; only the reserved bit is cut
      next_precharge = precharge_start[PWM_FIELDS_W-1:0];
      next_active    = active_charge[PWM_FIELDS_W-1:0];
      next_freewheel = freewheel[PWM_FIELDS_W-1:0];
   end

   // outputs are registered copies so the analog side sees clean levels;
   // the cost is one cycle of lag after a write
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_bridge_current  <= '0;
         o_precharge_start <= '0;
         o_active_charge   <= '0;
         o_freewheel_on    <= '0;
         o_freewheel_off   <= '0;
      end else begin
         o_bridge_current  <= next_bridge_current;
         o_precharge_start <= next_precharge;
         o_active_charge   <= next_active;
         o_freewheel_on    <= next_freewheel;
         o_freewheel_off   <= next_freewheel;
      end
   end

   // ---------------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------------
   a_bridge_set_one: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      !static_select[BRIDGE_SEL_LSB] |=> o_bridge_current[3:0] == $past(static_select[3:0]))
      else $error("bridge 1 not on set one");

   a_bridge_set_two: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      static_select[BRIDGE_SEL_LSB+7] |=> o_bridge_current[31:28] == $past(static_select[7:4]))
      else $error("bridge 8 not on set two");

   a_static_reset_codes: assert property (
      @(posedge i_clk) $rose(i_reset_n) |-> static_select == 16'h0044)
      else $error("static word wrong after reset");

   a_static_page_only: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_wr_en && hit_a && !i_page) |=> static_select == $past(i_wdata) && $stable(precharge_start))
      else $error("page zero write missed static word");

   a_precharge_page_only: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_wr_en && hit_a && i_page) |=> precharge_start == ($past(i_wdata) & 16'h7fff)
         && $stable(static_select))
      else $error("page one write missed precharge word");

   a_reserved_reads_zero: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_rd_en && (hit_b || (hit_a && i_page))) |=> o_rd_valid && !o_rdata[15])
      else $error("reserved bit read as one");

   a_freewheel_shared: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_wr_en && hit_b && i_page) |=> $stable(active_charge) ##1
         o_freewheel_on == $past(i_wdata[14:0], 2))
      else $error("freewheel write leaked or lost");

   a_active_read_back: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_wr_en && hit_b && !i_page) ##1 (i_rd_en && hit_b && !i_page && !i_wr_en)
         |=> o_rdata == ($past(i_wdata, 2) & 16'h7fff))
      else $error("active word read back wrong");

   a_freewheel_both_edges: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      $past(i_reset_n) |-> o_freewheel_off == $past(freewheel[14:0])
         && o_freewheel_on == o_freewheel_off)
      else $error("freewheel on and off codes differ");

   a_page_isolation: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_wr_en && hit_b && !i_page) |=> $stable(freewheel))
      else $error("page zero write changed page one word");

   a_reserved_never_set: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      !precharge_start[15] && !active_charge[15] && !freewheel[15])
      else $error("reserved bit of a pwm word holds one");

   a_precharge_follows: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      $past(i_reset_n) |-> o_precharge_start == $past(precharge_start[14:0]))
      else $error("precharge codes not on outputs");

   a_active_follows: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      $past(i_reset_n) |-> o_active_charge == $past(active_charge[14:0]))
      else $error("active charge codes not on outputs");

   a_other_offset_keep: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_wr_en && hit_a) |=> $stable(active_charge) && $stable(freewheel))
      else $error("offset 0a write changed an offset 0b word");
endmodule : gate_drive_current_regs
`default_nettype wire

// >>> tb/host_port_model.sv
// host model that makes register accesses into the current bank
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
   input  wire logic        i_clk,
   input  wire logic [15:0] i_rdata,
   input  wire logic        i_rd_valid,
   output var  logic        o_page,
   output var  logic        o_wr_en,
   output var  logic        o_rd_en,
   output var  logic [4:0]  o_addr,
   output var  logic [15:0] o_wdata
);
   logic [15:0] rd_word; // word seen after the read edge
   logic        rd_seen; // valid pulse seen with it
   // idle lines at time zero
   initial begin
      o_page  = 1'b0;
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr  = 5'h1f;
      o_wdata = 16'h0000;
   end
   // one access: strobe for a single edge, then capture the answer
   task automatic access(input logic page, input logic wr, input logic [4:0] addr,
                         input logic [15:0] wdata);
      @(posedge i_clk);
      o_page  <= page;
      o_wr_en <= wr;
      o_rd_en <= ~wr;
      o_addr  <= addr;
      o_wdata <= wdata;
      @(posedge i_clk);
      o_wr_en <= 1'b0;
      o_rd_en <= 1'b0;
      // released lines invert so a stale value is never mistaken for a request
      o_page  <= ~page;
      o_addr  <= ~addr;
      o_wdata <= ~wdata;
      #1;
      rd_seen = i_rd_valid;
      rd_word = i_rdata;
   endtask : access
   // write on one edge, read the same word on the very next edge
   task automatic write_read(input logic page, input logic [4:0] addr,
                             input logic [15:0] wdata);
      @(posedge i_clk);
      o_page  <= page;
      o_wr_en <= 1'b1;
      o_rd_en <= 1'b0;
      o_addr  <= addr;
      o_wdata <= wdata;
      @(posedge i_clk);
      o_wr_en <= 1'b0;
      o_rd_en <= 1'b1;
      o_wdata <= ~wdata;
      @(posedge i_clk);
      o_rd_en <= 1'b0;
      o_page  <= ~page;
      o_addr  <= ~addr;
      #1;
      rd_seen = i_rd_valid;
      rd_word = i_rdata;
   endtask : write_read
endmodule : host_port_model
`default_nettype wire

// >>> tb/tb_gate_drive_current_regs.sv
// self-checking bench for the gate current register bank
`timescale 1ns/100ps
`default_nettype none
module tb_gate_drive_current_regs;
   typedef struct packed {
      logic        page;
      logic [4:0]  addr;
      logic [15:0] wdata;
      logic [15:0] exp;
   } row_t;
   logic        i_clk = 1'b0;     // 100 MHz
   logic        i_reset_n = 1'b0; // held low from the start
   logic        page, wr_en, rd_en, rd_valid;
   logic [4:0]  addr;
   logic [15:0] wdata, rdata;
   logic [31:0] bridge;           // static code per bridge
   logic [14:0] pre, act, fw_on, fw_off;
   int          errors = 0;
   int          total_checks = 0;
   // write value beside the readback that it should give
   row_t rows [4] = '{'{1'b0, 5'h0a, 16'h8f3c, 16'h8f3c}, '{1'b1, 5'h0a, 16'hffff, 16'h7fff},
                      '{1'b0, 5'h0b, 16'haaaa, 16'h2aaa}, '{1'b1, 5'h0b, 16'h5555, 16'h5555}};
   gate_drive_current_regs dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_page(page),
      .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
      .o_rd_valid(rd_valid), .o_bridge_current(bridge), .o_precharge_start(pre),
      .o_active_charge(act), .o_freewheel_on(fw_on), .o_freewheel_off(fw_off));
   host_port_model host (.i_clk(i_clk), .i_rdata(rdata), .i_rd_valid(rd_valid),
      .o_page(page), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
   // clock
   always #5 i_clk = ~i_clk;
   // one comparison, counted
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // read one word and compare both valid pulse and data
   task automatic rd_check(input logic pg, input logic [4:0] a, input logic [15:0] exp);
      host.access(pg, 1'b0, a, 16'h0000);
      check(32'(host.rd_seen), 32'h1);
      check(32'(host.rd_word), 32'(exp));
   endtask : rd_check
   // synchronous reset for three cycles, then let the code outputs settle
   task automatic do_reset;
      @(posedge i_clk);
      i_reset_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_reset_n <= 1'b1;
      #1;
      // outputs are still cleared while reset was sampled low
      check(bridge, 32'h0);
      check(32'(rd_valid), 32'h0);
      check(32'(rdata), 32'h0);
      repeat (2) @(posedge i_clk);
      #1;
   endtask : do_reset
   // verdict
   task automatic report_and_stop;
      $display("errors=%0d total_checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   // watchdog, well beyond the roughly 60 cycles the tests need
   initial begin
      #100000;
      errors++;
      report_and_stop();
   end
   // main sequence
   initial begin
      do_reset();
      check(bridge, 32'h44444444);
      check(32'(pre), 32'h18c6);
      check(32'(act), 32'h18c6);
      check(32'(fw_on), 32'h18c6);
      check(32'(fw_off), 32'h18c6);
      for (int i = 0; i < 4; i++) begin
         rd_check(rows[i].page, rows[i].addr, i == 0 ? 16'h0044 : 16'h18c6);
      end
      // table rows: write then read back at once
      for (int i = 0; i < 4; i++) begin
         host.access(rows[i].page, 1'b1, rows[i].addr, rows[i].wdata);
         rd_check(rows[i].page, rows[i].addr, rows[i].exp);
      end
      // later page writes must not have touched the other page
      for (int i = 0; i < 4; i++) begin
         rd_check(rows[i].page, rows[i].addr, rows[i].exp);
      end
      // bridges 1-4 and 8 selected onto code b (3), the rest on code a (c)
      check(bridge, 32'h3ccc3333);
      check(32'(pre), 32'h7fff);
      check(32'(act), 32'h2aaa);
      check(32'(fw_on), 32'h5555);
      check(32'(fw_off), 32'h5555);
      // unmapped write ignored, unmapped read answers zero
      host.access(1'b0, 1'b1, 5'h0c, 16'h1234);
      rd_check(1'b0, 5'h0b, 16'h2aaa);
      rd_check(1'b0, 5'h0c, 16'h0000);
      // back-to-back write then read on each page, top bit dropped on pwm words
      host.write_read(1'b0, 5'h0b, 16'hf0f0);
      check(32'(host.rd_seen), 32'h1);
      check(32'(host.rd_word), 32'h70f0);
      check(32'(act), 32'h70f0);
      host.write_read(1'b1, 5'h0a, 16'h8001);
      check(32'(host.rd_word), 32'h0001);
      check(32'(pre), 32'h0001);
      rd_check(1'b0, 5'h0a, 16'h8f3c);
      // second reset in mid-run restores every word
      do_reset();
      rd_check(1'b0, 5'h0a, 16'h0044);
      rd_check(1'b1, 5'h0b, 16'h18c6);
      check(32'(fw_off), 32'h18c6);
      report_and_stop();
   end
endmodule : tb_gate_drive_current_regs
`default_nettype wire
